// ==== msad_core_mdl.sv ====
// Purpose: core read and write address unit model
// Assumes: drives on falling edge
// Notes: released address is inverted
`timescale 1ns/10ps
module msad_core_mdl(
	input wire core_clk,
	output logic rd_req,
	output logic rd_byte,
	output logic [15:0] rd_ea,
	output logic wr_req,
	output logic wr_byte,
	output logic [15:0] wr_ea,
	output logic [15:0] wr_data
);
	initial {rd_req, rd_byte, rd_ea, wr_req, wr_byte, wr_ea, wr_data} = 52'h0;
	task rd(input [15:0] a, input b);
		@(negedge core_clk) {rd_req, rd_byte, rd_ea} = {1'b1, b, a};
		@(negedge core_clk) {rd_req, rd_ea} = {1'b0, ~a};
	endtask
	task wr(input [15:0] a, d, input b);
		@(negedge core_clk) {wr_req, wr_byte, wr_ea, wr_data} = {1'b1, b, a, d};
		@(negedge core_clk) {wr_req, wr_ea} = {1'b0, ~a};
	endtask
endmodule // msad_core_mdl

// ==== msad_data_ram.v ====
// Purpose: small word-wide data memory with byte lanes
// Assumes: synchronous inputs, one clock
// Notes: lsb at even address, msb at odd address
`timescale 1ns/10ps
`include "msad_map.vh"
module msad_data_ram (
	core_clk,
	wr_en,
	wr_byte,
	wr_ea,
	wr_data,
	rd_ea,
	rd_word
);
	input wire core_clk;
	input wire wr_en;
	input wire wr_byte;
	input wire [15:0] wr_ea;
	input wire [15:0] wr_data;
	input wire [15:0] rd_ea;
	output wire [15:0] rd_word;
	reg [15:0] mem_ff [0:`MSAD_RAM_WORDS-1];
	wire [3:0] wr_idx;
	wire [3:0] rd_idx;
	assign wr_idx = wr_ea[4:1];
	assign rd_idx = rd_ea[4:1];
	assign rd_word = mem_ff[rd_idx];
	// ------------------------------------------------------------
	// byte lanes
	// ------------------------------------------------------------
	always @(posedge core_clk) begin
		if (wr_en && (!wr_byte || !wr_ea[0])) begin
			mem_ff[wr_idx][7:0] <= wr_data[7:0]; // R14
		end
		if (wr_en && (!wr_byte || wr_ea[0])) begin
			mem_ff[wr_idx][15:8] <= wr_byte ? wr_data[7:0] : wr_data[15:8]; // R14
		end
	end
endmodule // msad_data_ram

// ==== msad_decode.v ====
// Purpose: program and data space address forming and decode
// Assumes: core fetch and address units drive synchronous requests
// Notes: all outputs registered
//
// Summary of operation
// R1 - program address 24 bits from pc/table
// R2 - user accesses limited to lower half
// R3 - table page bit 7 reaches config space
// R4 - program location 24 bits, two words
// R5 - lower word even, upper word odd
// R6 - pc word aligned, steps by two
// R7 - addresses below 0x200 are vectors
// R8 - reset starts at zero, jump target 0x2
// R9 - primary and alternate vector tables
// R10 - 16-bit data, separate read/write units
// R11 - 16-bit byte effective data addresses
// R12 - ea bit 15 selects visibility window
// R13 - reads outside ram return zero
// R14 - lsb even address, msb odd address
// R15 - program space up to 4M locations
`timescale 1ns/10ps
`include "msad_map.vh"
module msad_decode (
	core_clk,
	rst,
	pc_step,
	pc_down,
	pc_load,
	pc_load_addr,
	tbl_req,
	table_page_register,
	tbl_offset,
	tbl_upper,
	vec_req,
	vec_alt,
	vec_num,
	rd_req,
	rd_byte,
	rd_ea,
	wr_req,
	wr_byte,
	wr_ea,
	wr_data,
	pc_ff,
	prog_addr_ff,
	prog_upper_ff,
	prog_viol_ff,
	prog_cfg_ff,
	prog_vec_ff,
	data_ff,
	psv_hit_ff,
	psv_addr_ff,
	data_oor_ff
);
	input wire core_clk;
	input wire rst;
	input wire pc_step;
	input wire pc_down;
	input wire pc_load;
	input wire [22:0] pc_load_addr;
	input wire tbl_req;
	input wire [7:0] table_page_register;
	input wire [15:0] tbl_offset;
	input wire tbl_upper;
	input wire vec_req;
	input wire vec_alt;
	input wire [6:0] vec_num;
	input wire rd_req;
	input wire rd_byte;
	input wire [15:0] rd_ea;
	input wire wr_req;
	input wire wr_byte;
	input wire [15:0] wr_ea;
	input wire [15:0] wr_data;
	output reg [22:0] pc_ff;
	output reg [23:0] prog_addr_ff;
	output reg prog_upper_ff;
	output reg prog_viol_ff;
	output reg prog_cfg_ff;
	output reg prog_vec_ff;
	output reg [15:0] data_ff;
	output reg psv_hit_ff;
	output reg [23:0] psv_addr_ff;
	output reg data_oor_ff;

	wire [15:0] ram_word;
	reg [22:0] nxt_pc;
	reg [23:0] nxt_addr;
	reg nxt_viol;
	reg nxt_cfg;
	reg [15:0] rd_sel;
	wire rd_in_ram;
	wire wr_in_ram;
	reg [23:0] pc_sum;
	reg nxt_upper;
	reg nxt_vec;
	reg [15:0] nxt_data;
	reg nxt_psv_hit;
	reg [23:0] nxt_psv_addr;
	reg nxt_oor;
	wire [23:0] vec_base;
	wire [23:0] vec_ofs;
	wire [7:0] rd_lo;
	wire [7:0] rd_hi;
	wire [23:0] psv_addr;
	wire rd_low_half;
	wire rd_below_top;
	wire wr_low_half;
	wire wr_below_top;
	wire ram_wr_en;
	// ------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------
	always @* begin
		nxt_pc = pc_ff;
		pc_sum = {1'b0, pc_ff};
		if (pc_load) begin
			nxt_pc = {pc_load_addr[22:1], 1'b0}; // R6
		end else if (pc_step && pc_down) begin
			pc_sum = {1'b0, pc_ff} - `MSAD_PC_STEP; // R6
			nxt_pc = pc_sum[22:0];
		end else if (pc_step) begin
			pc_sum = {1'b0, pc_ff} + `MSAD_PC_STEP; // R6
			nxt_pc = pc_sum[22:0];
		end
	end
	// ------------------------------------------------------------
	// vector table select
	// ------------------------------------------------------------
	assign vec_base = vec_alt ? `MSAD_AIVT_BASE : `MSAD_IVT_BASE; // R9
	assign vec_ofs = {16'h0000, vec_num, 1'b0}; // R9
	// ------------------------------------------------------------
	// program address forming
	// ------------------------------------------------------------
	always @* begin
		nxt_addr = {1'b0, pc_ff}; // R1 R15
		nxt_cfg = 1'b0;
		nxt_viol = 1'b0;
		if (vec_req) begin
			nxt_addr = vec_base + vec_ofs; // R9
		end else if (tbl_req) begin
			nxt_addr = {table_page_register, tbl_offset[15:1], tbl_upper}; // R1 R5
			nxt_cfg = table_page_register[`MSAD_PAGE_CFG_BIT]; // R3
		end
		if (!tbl_req && nxt_addr > `MSAD_USER_TOP) begin
			nxt_viol = 1'b1; // R2
		end
	end
	// ------------------------------------------------------------
	// data decode
	// ------------------------------------------------------------
	assign rd_low_half = !rd_ea[`MSAD_EA_PSV_BIT]; // R12
	assign rd_below_top = (rd_ea < `MSAD_RAM_TOP); // R13
	assign rd_in_ram = rd_low_half && rd_below_top; // R12 R13
	assign wr_low_half = !wr_ea[`MSAD_EA_PSV_BIT]; // R12
	assign wr_below_top = (wr_ea < `MSAD_RAM_TOP); // R13
	assign wr_in_ram = wr_low_half && wr_below_top; // R10
	assign ram_wr_en = wr_req && wr_in_ram; // R10
	assign rd_lo = ram_word[7:0]; // R14
	assign rd_hi = ram_word[15:8]; // R14
	assign psv_addr = {1'b0, table_page_register, rd_ea[14:0]}; // R12
	always @* begin
		rd_sel = ram_word;
		if (!rd_in_ram) begin
			rd_sel = 16'h0000; // R13
		end else if (rd_byte) begin
			rd_sel = {8'h00, rd_ea[0] ? rd_hi : rd_lo}; // R14
		end
	end
	msad_data_ram msad_data_ram_inst (
		.core_clk(core_clk),
		.wr_en(ram_wr_en),
		.wr_byte(wr_byte),
		.wr_ea(wr_ea),
		.wr_data(wr_data),
		.rd_ea(rd_ea),
		.rd_word(ram_word)
	);
	// ------------------------------------------------------------
	// next values of the registered outputs
	// ------------------------------------------------------------
	always @* begin
		nxt_upper = nxt_addr[0]; // R4 R5
		nxt_vec = (nxt_addr < `MSAD_VEC_TOP); // R7
		nxt_data = data_ff;
		nxt_psv_hit = psv_hit_ff;
		nxt_psv_addr = psv_addr_ff;
		nxt_oor = data_oor_ff;
		if (rd_req) begin
			nxt_data = rd_sel; // R11
			nxt_psv_hit = rd_ea[`MSAD_EA_PSV_BIT]; // R12
			nxt_psv_addr = psv_addr; // R12
			nxt_oor = !rd_in_ram; // R13
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pc_ff <= 23'h000000; // R8
			prog_addr_ff <= `MSAD_RESET_ADDR; // R8
			prog_upper_ff <= 1'b0;
			prog_viol_ff <= 1'b0;
			prog_cfg_ff <= 1'b0;
			prog_vec_ff <= 1'b1;
			data_ff <= 16'h0000;
			psv_hit_ff <= 1'b0;
			psv_addr_ff <= 24'h000000;
			data_oor_ff <= 1'b0;
		end else begin
			pc_ff <= nxt_pc;
			prog_addr_ff <= nxt_addr;
			prog_upper_ff <= nxt_upper;
			prog_viol_ff <= nxt_viol; // R2
			prog_cfg_ff <= nxt_cfg;
			prog_vec_ff <= nxt_vec;
			data_ff <= nxt_data;
			psv_hit_ff <= nxt_psv_hit;
			psv_addr_ff <= nxt_psv_addr;
			data_oor_ff <= nxt_oor;
		end
	end
endmodule // msad_decode

// ==== msad_decode_bench.sv ====
// Purpose: bench for msad_decode
// Assumes: inputs change on falling edge
// Notes: data requests come from the core model
`timescale 1ns/10ps
module msad_decode_bench;
	logic core_clk = 1'b0, rst = 1'b1, pc_step = 1'b0, pc_down = 1'b0, pc_load = 1'b0;
	logic tbl_req = 1'b0, tbl_upper = 1'b0, vec_req = 1'b0, vec_alt = 1'b0;
	logic [22:0] pc_load_addr = 23'h0;
	logic [7:0] table_page_register = 8'h0;
	logic [15:0] tbl_offset = 16'h0;
	logic [6:0] vec_num = 7'h0;
	logic rd_req, rd_byte, wr_req, wr_byte, prog_upper_ff, prog_viol_ff;
	logic prog_cfg_ff, prog_vec_ff, psv_hit_ff, data_oor_ff;
	logic [15:0] rd_ea, wr_ea, wr_data, data_ff;
	logic [22:0] pc_ff;
	logic [23:0] prog_addr_ff, psv_addr_ff;
	int error_cnt = 0, total_checks = 0;
	always #12.5 core_clk = ~core_clk;
	msad_decode msad_decode_inst(.*);
	msad_core_mdl msad_core_mdl_inst(.*);
	task chk(input [23:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task t_rst;
		chk({1'b0, pc_ff}, 24'h0);
		pc_step = 1'b1;
		@(negedge core_clk) pc_step = 1'b0;
		chk({1'b0, pc_ff}, 24'h000002);
	endtask
	task t_pc;
		{pc_load, pc_load_addr} = {1'b1, 23'h7FFFFF};
		@(negedge core_clk) {pc_load, pc_step, pc_down} = 3'h3;
		chk({1'b0, pc_ff}, 24'h7FFFFE);
		@(negedge core_clk) pc_step = 1'b0;
		chk({1'b0, pc_ff}, 24'h7FFFFC);
		@(negedge core_clk) chk(prog_addr_ff, 24'h7FFFFC);
		chk(prog_vec_ff, 24'h0);
		chk(prog_viol_ff, 24'h0);
	endtask
	task t_vec;
		{vec_req, vec_num} = {1'b1, 7'h02};
		repeat (2) @(negedge core_clk);
		chk(prog_addr_ff, 24'h000008);
		vec_alt = 1'b1;
		repeat (2) @(negedge core_clk);
		chk(prog_addr_ff, 24'h000104);
		chk(prog_vec_ff, 24'h1);
		vec_req = 1'b0;
	endtask
	task t_tbl;
		{tbl_req, tbl_upper, table_page_register, tbl_offset} = {2'h3, 8'h80, 16'h0011};
		repeat (2) @(negedge core_clk);
		chk(prog_addr_ff, 24'h800011);
		chk({prog_cfg_ff, prog_upper_ff}, 24'h3);
		chk(prog_viol_ff, 24'h0);
		{tbl_req, table_page_register} = {1'b0, 8'h12};
	endtask
	task t_data;
		msad_core_mdl_inst.wr(16'h0004, 16'hA5B6, 1'b0);
		msad_core_mdl_inst.rd(16'h0005, 1'b1);
		chk(data_ff, 24'h00A5);
		msad_core_mdl_inst.rd(16'h0004, 1'b1);
		chk(data_ff, 24'h00B6);
		msad_core_mdl_inst.rd(16'h0004, 1'b0);
		chk(data_ff, 24'hA5B6);
		msad_core_mdl_inst.rd(16'h7800, 1'b0);
		chk({data_oor_ff, data_ff}, 24'h10000);
		chk(psv_hit_ff, 24'h0);
		msad_core_mdl_inst.rd(16'h8123, 1'b0);
		chk(psv_addr_ff, 24'h090123);
		chk(psv_hit_ff, 24'h1);
	endtask
	task t_rst2;
		rst = 1'b1;
		@(negedge core_clk) chk(prog_addr_ff, 24'h0);
		chk({prog_vec_ff, pc_ff}, 24'h800000);
		chk({data_oor_ff, data_ff}, 24'h0);
		rst = 1'b0;
		@(negedge core_clk) chk(prog_addr_ff, 24'h0);
	endtask
	task end_of_test;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		t_rst;
		t_pc;
		t_vec;
		t_tbl;
		t_data;
		t_rst2;
		end_of_test;
	end
	initial begin
		#100000;
		error_cnt++;
		end_of_test;
	end
endmodule // msad_decode_bench
bind msad_decode msad_sva msad_sva_inst(.*);

// ==== msad_map.vh ====
// Purpose: constants for the memory space address decode block
// Assumes: 40 MHz core clock
// Notes: addresses are byte or program-word addresses as noted
`ifndef MSAD_MAP_VH
`define MSAD_MAP_VH
`define MSAD_PADDR_W 24
`define MSAD_PC_W 23
`define MSAD_USER_TOP 24'h7FFFFF
`define MSAD_RESET_ADDR 24'h000000
`define MSAD_RESET_TGT 24'h000002
`define MSAD_IVT_BASE 24'h000004
`define MSAD_AIVT_BASE 24'h000100
`define MSAD_AIVT_TOP 24'h0001FF
`define MSAD_VEC_TOP 24'h000200
`define MSAD_PC_STEP 24'h000002
`define MSAD_PAGE_CFG_BIT 7
`define MSAD_EA_W 16
`define MSAD_EA_PSV_BIT 15
`define MSAD_RAM_TOP 16'h7800
`define MSAD_RAM_WORDS 16
`define MSAD_DW 16
`endif

// ==== msad_sva.sv ====
// Purpose: checker for msad_decode
// Assumes: one clock, async reset
// Notes: bound from the bench
`timescale 1ns/10ps
module msad_sva(
	input wire core_clk,
	input wire rst,
	input wire pc_load,
	input wire pc_step,
	input wire pc_down,
	input wire [22:0] pc_load_addr,
	input wire rd_req,
	input wire [15:0] rd_ea,
	input wire [22:0] pc_ff,
	input wire [23:0] prog_addr_ff,
	input wire prog_upper_ff,
	input wire prog_cfg_ff,
	input wire prog_viol_ff,
	input wire prog_vec_ff,
	input wire [15:0] data_ff,
	input wire psv_hit_ff,
	input wire data_oor_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_step;
		pc_step && !pc_load;
	endsequence
	sequence s_rd_oor;
		rd_req && !rd_ea[15] && rd_ea >= 16'h7800;
	endsequence
	AST_PC_EVEN: assert property (!pc_ff[0])
		else $error("pc odd");
	AST_PC_LOAD: assert property (pc_load |=> pc_ff == ($past(pc_load_addr) & 23'h7FFFFE))
		else $error("pc load");
	AST_PC_STEP: assert property (s_step |=>
		pc_ff == $past(pc_ff) + ($past(pc_down) ? 23'h7FFFFE : 23'h000002))
		else $error("pc step");
	AST_VEC: assert property (prog_vec_ff == (prog_addr_ff < 24'h000200))
		else $error("vec flag");
	AST_UPPER: assert property (prog_upper_ff == prog_addr_ff[0])
		else $error("upper flag");
	AST_CFG: assert property (prog_cfg_ff |-> prog_addr_ff[23])
		else $error("cfg flag");
	AST_PSV: assert property (rd_req |=> psv_hit_ff == $past(rd_ea[15]))
		else $error("psv flag");
	AST_OOR: assert property (s_rd_oor |=> data_oor_ff && data_ff == 16'h0000)
		else $error("oor read");
	AST_USER: assert property (!prog_cfg_ff |-> !prog_addr_ff[23] && !prog_viol_ff)
		else $error("user range");
endmodule // msad_sva
